// *** inc/flash_cmd_defs.svh ***
// Purpose: Constants for the erase, write-enable and sector-protect command block
// Assumes: 100 MHz core clock
// Notes: Sector geometry and erase time are plain defaults, not device figures
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hc7
`define OP_PROTECT_SECTOR 8'h36

// ----------------------------------------
// Geometry and reset values
// ----------------------------------------
`define ADDR_BYTES 3'd3
`define BYTE_CNT_MAX 3'd4
`define SECTOR_COUNT 4
`define SECTOR_MSB 17
`define SECTOR_LSB 16
`define PROT_RESET 4'hf
`define CS_SYNC_RESET 3'h4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define CHIP_ERASE_TIME_MS 4000
`define CHIP_ERASE_CYCLES (`CHIP_ERASE_TIME_MS * (1000000 / `CLK_PERIOD_NS))

`endif

// *** inc/flash_cmd_pkg.sv ***
// Purpose: Types shared by the command block, the SPI host model and the bench
// Assumes: Nothing beyond SystemVerilog packed types
// Notes: State codes are one-hot
package flash_cmd_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ERASE = 2'b10
    } erase_state_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } spi_pins_t;

endpackage

// *** core/pin_sync3.sv ***
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to i_clk
// Notes: Output changes only once stages two and three agree
module pin_sync3 #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_level
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    // Stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_level <= RESET_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    o_level[i] <= s3_reg[i];
                end
            end
        end
    end

endmodule

// *** core/erase_wel_sector_protect.sv ***
// Purpose: Chip erase, write enable/disable and sector protect command handling
// Assumes: SPI mode 0 or 3, data sampled on rising serial clock
// Notes: Serial pins are oversampled by the core clock; SCK must stay well below 1/8 of it
`include "flash_cmd_defs.svh"

module erase_wel_sector_protect #(
    parameter int unsigned ERASE_CYCLES = `CHIP_ERASE_CYCLES
) (
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    input wire flash_cmd_pkg::spi_pins_t I_SPI,
    input wire logic I_PROT_LOCK,
    input wire logic I_ERASE_FAIL,
    output logic O_WEL,
    output logic O_BUSY,
    output logic O_EPE,
    output logic [`SECTOR_COUNT-1:0] O_SECTOR_PROT
);
    import flash_cmd_pkg::*;

    // ----------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------
    spi_pins_t pins;
    logic cs_n_prev_reg;
    logic sck_prev_reg;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;

    pin_sync3 #(
        .WIDTH(3),
        .RESET_VAL(`CS_SYNC_RESET)
    ) u_pin_sync (
        .i_clk(I_CORE_CLK),
        .i_rst(I_SYS_RST),
        .i_async(I_SPI),
        .o_level(pins)
    );

    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            cs_n_prev_reg <= 1'b1;
            sck_prev_reg <= 1'b0;
        end else begin
            cs_n_prev_reg <= pins.cs_n;
            sck_prev_reg <= pins.sck;
        end
    end

    assign cs_fall = cs_n_prev_reg & ~pins.cs_n;
    assign cs_rise = ~cs_n_prev_reg & pins.cs_n;
    assign sck_rise = ~sck_prev_reg & pins.sck & ~pins.cs_n;

    // ----------------------------------------
    // Bit and byte counting, shifting
    // ----------------------------------------
    logic [2:0] bit_cnt_reg;
    logic [2:0] byte_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] opcode_reg;
    logic [23:0] addr_reg;
    logic [7:0] byte_in;

    assign byte_in = {shift_reg[6:0], pins.si};

    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else if (cs_fall) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= byte_in;
            // Saturate so long trailing data cannot wrap the count
            if (bit_cnt_reg == 3'h7 && byte_cnt_reg != `BYTE_CNT_MAX) begin
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            opcode_reg <= 8'h00;
            addr_reg <= 24'h000000;
        end else if (cs_fall) begin
            // Cleared so a cut frame cannot reapply the previous command
            opcode_reg <= 8'h00;
        end else if (sck_rise && bit_cnt_reg == 3'h7) begin
            // Bytes after the address are ignored
            if (byte_cnt_reg == 3'h0) begin
                opcode_reg <= byte_in;
            end else if (byte_cnt_reg <= `ADDR_BYTES) begin
                addr_reg <= {addr_reg[15:0], byte_in};
            end
        end
    end

    // ----------------------------------------
    // Command decode at chip select release
    // ----------------------------------------
    erase_state_t state_reg;
    logic wel_reg;
    logic [`SECTOR_COUNT-1:0] prot_reg;
    logic aligned;
    logic full_addr;
    logic prot_any;
    logic idle;
    logic is_ce;
    logic is_we;
    logic is_wd;
    logic is_ps;
    logic start_erase;
    logic wel_next;
    logic [`SECTOR_COUNT-1:0] prot_next;
    logic [1:0] sector;

    assign aligned = (bit_cnt_reg == 3'h0) && (byte_cnt_reg != 3'h0);
    assign full_addr = byte_cnt_reg > `ADDR_BYTES;
    assign prot_any = |prot_reg;
    assign idle = (state_reg == ST_IDLE);
    assign is_ce = (opcode_reg == `OP_CHIP_ERASE_A) || (opcode_reg == `OP_CHIP_ERASE_B);
    assign is_we = opcode_reg == `OP_WRITE_ENABLE;
    assign is_wd = opcode_reg == `OP_WRITE_DISABLE;
    assign is_ps = opcode_reg == `OP_PROTECT_SECTOR;
    assign sector = addr_reg[`SECTOR_MSB:`SECTOR_LSB];
    // Commands arriving while erasing are dropped; the array is unavailable
    assign start_erase = cs_rise && idle && is_ce && wel_reg && aligned && !prot_any;

    always_comb begin
        wel_next = wel_reg;
        prot_next = prot_reg;
        if (cs_rise && idle && aligned) begin
            if (is_we) begin
                wel_next = 1'b1;
            end else if (is_wd) begin
                wel_next = 1'b0;
            end
        end
        if (cs_rise && idle && wel_reg) begin
            if (is_ce) begin
                wel_next = 1'b0;
            end else if (is_ps) begin
                wel_next = 1'b0;
                if (!I_PROT_LOCK && full_addr && aligned) begin
                    prot_next[sector] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            wel_reg <= 1'b0;
        end else begin
            wel_reg <= wel_next;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            prot_reg <= `PROT_RESET;
        end else begin
            prot_reg <= prot_next;
        end
    end

    // ----------------------------------------
    // Erase sequencing and error flag
    // ----------------------------------------
    logic [31:0] timer_reg;
    logic epe_reg;
    logic erase_end;

    assign erase_end = (state_reg == ST_ERASE) && (timer_reg == 32'h0);

    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_reg <= ST_IDLE;
            timer_reg <= 32'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_erase) begin
                        state_reg <= ST_ERASE;
                        timer_reg <= 32'(ERASE_CYCLES - 1);
                    end
                end
                ST_ERASE: begin
                    // Self-timed; no serial clocks are needed to finish
                    if (timer_reg == 32'h0) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        timer_reg <= timer_reg - 32'h1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Flag reflects the last erase: fresh result at each completion
    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            epe_reg <= 1'b0;
        end else if (erase_end) begin
            epe_reg <= I_ERASE_FAIL;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign O_WEL = wel_reg;
    assign O_BUSY = state_reg[1];
    assign O_EPE = epe_reg;
    assign O_SECTOR_PROT = prot_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_SYS_RST);

    chk_erase_needs_wel: assert property (start_erase |-> wel_reg)
        else $error("erase started without write enable");
    chk_erase_opcodes: assert property (
        $rose(O_BUSY) |-> $past(opcode_reg) inside {`OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B})
        else $error("erase started by a wrong opcode");
    chk_erase_at_release: assert property ($rose(O_BUSY) |-> $past(cs_rise))
        else $error("erase started without chip select release");
    chk_erase_ends: assert property (erase_end |=> !O_BUSY && O_EPE == $past(I_ERASE_FAIL))
        else $error("erase did not end on timer expiry");
    chk_timer_bound: assert property (O_BUSY |-> timer_reg < ERASE_CYCLES)
        else $error("erase timer beyond erase time");
    chk_erase_aligned: assert property ($rose(O_BUSY) |-> $past(aligned))
        else $error("erase after misaligned release");
    chk_erase_unprot: assert property ($rose(O_BUSY) |-> $past(prot_reg) == '0)
        else $error("erase with a protected sector");
    chk_reject_wel: assert property (
        cs_rise && idle && is_ce && wel_reg && (!aligned || prot_any)
        |=> !O_WEL && !O_BUSY)
        else $error("rejected erase kept the latch");
    chk_busy_status: assert property ($rose(O_BUSY) |-> O_BUSY [*3])
        else $error("busy dropped early");
    chk_erase_wel_clr: assert property (O_BUSY |-> !O_WEL)
        else $error("latch set during erase");
    chk_error_flag: assert property (erase_end && I_ERASE_FAIL |=> O_EPE)
        else $error("erase failure not flagged");
    chk_wel_set: assert property (cs_rise && idle && aligned && is_we |=> O_WEL)
        else $error("write enable did not set latch");
    chk_no_wel_no_run: assert property (
        cs_rise && !wel_reg |=> !$rose(O_BUSY) && $stable(prot_reg))
        else $error("command ran without write enable");
    chk_wel_clear: assert property (cs_rise && idle && aligned && is_wd |=> !O_WEL)
        else $error("write disable did not clear latch");
    chk_wel_hold: assert property (
        cs_rise && idle && !aligned && (is_we || is_wd) |=> $stable(O_WEL))
        else $error("misaligned write enable changed latch");
    chk_prot_reset: assert property ($fell(I_SYS_RST) |-> prot_reg == `PROT_RESET)
        else $error("protection bits not set at reset");
    chk_prot_monotonic: assert property ((~prot_reg & $past(prot_reg)) == '0)
        else $error("protection bit cleared");
    chk_prot_set: assert property (
        cs_rise && idle && wel_reg && is_ps && !I_PROT_LOCK && aligned && full_addr
        |=> O_SECTOR_PROT[$past(sector)] && !O_WEL)
        else $error("protect sector did not take effect");
    chk_prot_abort: assert property (
        cs_rise && idle && wel_reg && is_ps && (!aligned || !full_addr)
        |=> $stable(O_SECTOR_PROT) && !O_WEL)
        else $error("aborted protect changed state");
    chk_prot_locked: assert property (
        cs_rise && idle && wel_reg && is_ps && I_PROT_LOCK |=> $stable(O_SECTOR_PROT) && !O_WEL)
        else $error("locked protect not ignored");
    chk_bit_count: assert property (sck_rise |=> bit_cnt_reg == $past(bit_cnt_reg) + 3'h1)
        else $error("serial bit not counted");

    cov_chip_erase: cover property ($rose(O_BUSY) ##[1:1000] erase_end);
    cov_wel_set: cover property (cs_rise && is_we && aligned ##1 O_WEL);
    cov_prot_set: cover property (cs_rise && is_ps && wel_reg && full_addr && aligned);
    cov_erase_fail: cover property (erase_end && I_ERASE_FAIL);

endmodule

// *** sim/spi_host_model.sv ***
// Purpose: Behavioural SPI host that frames flash commands for the command block
// Assumes: Mode 0, serial clock period 125 ns, MSB first
// Notes: Serial clock stands low between frames; data line shows the inverse once released
module spi_host_model (
    output flash_cmd_pkg::spi_pins_t o_pins
);
    timeunit 1ns;
    timeprecision 100ps;
    import flash_cmd_pkg::*;

    initial begin
        o_pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
    end

    // ----------------------------------------
    // One chip-select frame
    // ----------------------------------------
    // Bits go out from bits[31] down; nbits off a byte multiple only when a test asks
    task automatic frame(input logic [31:0] bits, input int nbits);
        int i;
        // Step off the core clock edge that the caller returned on
        #2.5;
        o_pins.cs_n = 1'b0;
        #62.5;
        for (i = 0; i < nbits; i++) begin
            o_pins.si = bits[31-i];
            #62.5;
            o_pins.sck = 1'b1;
            #62.5;
            o_pins.sck = 1'b0;
        end
        #62.5;
        o_pins.cs_n = 1'b1;
        // Released line must not keep looking like valid data
        o_pins.si = ~o_pins.si;
    endtask
endmodule

// *** sim/erase_wel_sector_protect_tb.sv ***
// Purpose: Self-checking bench for erase, write enable/disable and sector protect
// Assumes: Erase length shortened to 20 core cycles
// Notes: No unprotect command exists here, so every chip erase meets protected memory
module erase_wel_sector_protect_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_cmd_pkg::*;

    localparam int LIMIT = 20000;

    typedef struct {
        logic [31:0] bits;
        int nbits;
        logic lock;
        logic exp_wel;
    } row_t;

    logic core_clk;
    logic sys_rst;
    spi_pins_t spi_pins;
    logic prot_lock;
    logic erase_fail;
    logic wel;
    logic busy;
    logic erase_program_error;
    logic [3:0] sector_prot;
    int err_total;
    int samples_checked;
    int cycles;
    int r;

    // ----------------------------------------
    // Ordinary cases, applied in order from reset
    // ----------------------------------------
    row_t rows [13] = '{
        '{32'h06000000, 8, 1'b0, 1'b1},
        '{32'h04000000, 8, 1'b0, 1'b0},
        '{32'h06a50000, 16, 1'b0, 1'b1},
        '{32'h04000000, 10, 1'b0, 1'b1},
        '{32'h60000000, 8, 1'b0, 1'b0},
        '{32'h06000000, 8, 1'b0, 1'b1},
        '{32'hc75a3c00, 24, 1'b0, 1'b0},
        '{32'h60000000, 8, 1'b0, 1'b0},
        '{32'h06000000, 8, 1'b0, 1'b1},
        '{32'h04000000, 5, 1'b0, 1'b1},
        '{32'h36020000, 32, 1'b1, 1'b0},
        '{32'h06000000, 8, 1'b0, 1'b1},
        '{32'h36020000, 24, 1'b0, 1'b0}
    };

    spi_host_model host (
        .o_pins(spi_pins)
    );

    erase_wel_sector_protect #(
        .ERASE_CYCLES(20)
    ) DUT (
        .I_CORE_CLK(core_clk),
        .I_SYS_RST(sys_rst),
        .I_SPI(spi_pins),
        .I_PROT_LOCK(prot_lock),
        .I_ERASE_FAIL(erase_fail),
        .O_WEL(wel),
        .O_BUSY(busy),
        .O_EPE(erase_program_error),
        .O_SECTOR_PROT(sector_prot)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checked %0d values, %0d mismatches", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Frame, then give the pin synchroniser and the update time to land
    task automatic send(input logic [31:0] bits, input int nbits);
        host.frame(bits, nbits);
        repeat (12) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            $display("BAD t=%0t run took too long", $time);
            tally_and_finish();
        end
    end

    initial begin
        sys_rst = 1'b1;
        prot_lock = 1'b0;
        erase_fail = 1'b0;
        err_total = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (3) @(posedge core_clk);
        check(sector_prot, 4'hf, "reset protection");
        check({3'h0, wel}, 4'h0, "reset latch");
        sys_rst <= 1'b0;
        // A failed verify may only matter once an erase has actually run
        erase_fail <= 1'b1;
        repeat (6) @(posedge core_clk);
        $display("Test reset values done");

        // Rows cover set, clear, trailing bytes, partial frames, both erase codes, lock
        for (r = 0; r < 13; r++) begin
            @(posedge core_clk);
            prot_lock <= rows[r].lock;
            send(rows[r].bits, rows[r].nbits);
            check({3'h0, wel}, {3'h0, rows[r].exp_wel}, "latch");
            check({3'h0, busy}, 4'h0, "busy");
            check({3'h0, erase_program_error}, 4'h0, "error flag");
            check(sector_prot, 4'hf, "protection");
            $display("Test row %0d done", r);
        end

        // Protected memory also refuses an erase sent straight after enable
        @(posedge core_clk);
        prot_lock <= 1'b0;
        send(32'h06000000, 8);
        send(32'hc7000000, 8);
        // Poll busy rather than wait out the full erase time
        for (int k = 0; k < 30 && busy !== 1'b0; k++) begin
            @(posedge core_clk);
        end
        check({3'h0, busy}, 4'h0, "erase on protected array");
        check({3'h0, wel}, 4'h0, "latch after refused erase");
        $display("Test back to back done");

        // Second reset in mid-run restores defaults, then commands work again
        send(32'h06000000, 8);
        check({3'h0, wel}, 4'h1, "latch before reset");
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        check({3'h0, wel}, 4'h0, "latch in reset");
        check(sector_prot, 4'hf, "protection in reset");
        sys_rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        send(32'h06000000, 8);
        check({3'h0, wel}, 4'h1, "latch after second reset");
        $display("Test mid-run reset done");

        tally_and_finish();
    end
endmodule
